// ---- tcpu_core.sv ----
// Execution core of the twelve-bit processor: fetch, addressing, execute
`timescale 1ns/1ns
`include "tcpu_regs.svh"
module tcpu_core #(
    parameter int W = `TCPU_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] mem_rdata,
    input wire tcpu_pkg::tcpu_io_rsp_t io_rsp,
    output tcpu_pkg::tcpu_bus_t bus,
    output logic [W-1:0] working_register,
    output logic link,
    output logic [W-1:0] multiply_quotient_register,
    output logic [W-1:0] instruction_pointer,
    output logic [W-1:0] held_instruction,
    output tcpu_pkg::tcpu_step_t step
);
    // ==========
    // Elaboration check
    if (W != 12) begin : g_chk
        $error("tcpu_core serves twelve-bit words only");
    end

    tcpu_pkg::tcpu_state_t q, d;

    logic [2:0] opc;
    logic [W-1:0] ea_form, alu_ac, alu_mq;
    logic is_auto, opr_rot, alu_lnk, alu_skip;
    logic [4:0] total_calc;
    tcpu_pkg::tcpu_step_t after_ea;

    // ==========
    // Instruction field decode
    assign opc = q.ir[`TCPU_OPC_HI:`TCPU_OPC_LO]; // [RULE_09]

    // Page zero or the page the instruction came from
    assign ea_form = {
        q.ir[`TCPU_CUR_BIT] ? q.memory_address_latch[`TCPU_PAGE_HI:`TCPU_PAGE_LO] : 5'h00, // [RULE_10] [RULE_08]
        q.ir[`TCPU_OFS_HI:0] // [RULE_07] [RULE_06]
    };

    // Autoindex pointers sit at page zero 0010-0017 octal
    assign is_auto = (q.ea[W-1:3] == `TCPU_AUTO_TAG); // [RULE_12]

    // Group 1 with a rotate or swap takes the long form
    assign opr_rot = ~q.ir[8] & (q.ir[3:1] != 3'h0);

    // ==========
    // State count of the instruction just fetched
    always_comb begin
        case (opc)
            `TCPU_OP_AND,
            `TCPU_OP_ADD,
            `TCPU_OP_BR: total_calc = `TCPU_ST_SHORT; // [RULE_13] [RULE_18]
            `TCPU_OP_ISZ: total_calc = `TCPU_ST_ISZ; // [RULE_15]
            `TCPU_OP_DCA,
            `TCPU_OP_CALL: total_calc = `TCPU_ST_LONG; // [RULE_16]
            `TCPU_OP_IO: total_calc = `TCPU_ST_IO; // [RULE_19]
            default: total_calc = opr_rot ? `TCPU_ST_OPR_ROT : `TCPU_ST_SHORT; // [RULE_20]
        endcase
        if (opc < `TCPU_OP_IO && q.ir[`TCPU_IND_BIT]) begin
            total_calc = total_calc + `TCPU_ST_IND;
            if (ea_form[W-1:3] == `TCPU_AUTO_TAG) begin
                total_calc = total_calc + `TCPU_ST_AUTO;
            end
        end
    end

    // Operand read needed only by AND, add and increment
    assign after_ea = (opc <= `TCPU_OP_ISZ) ? tcpu_pkg::ST_OPRD : tcpu_pkg::ST_EXEC;

    // ==========
    // ALU
    tcpu_alu #(
        .W(W)
    ) u_alu (
        .opc(opc),
        .ir(q.ir),
        .ac(q.ac),
        .lnk(q.lnk),
        .mq(q.mq),
        .opnd(q.mb),
        .ac_o(alu_ac),
        .lnk_o(alu_lnk),
        .mq_o(alu_mq),
        .skip_o(alu_skip)
    );

    // ==========
    // Sequencer: phase 0 strobes, phase 1 samples; ST_PAD pads to the state count
    always_comb begin
        d = q;
        d.bus.rd = 1'b0;
        d.bus.wr = 1'b0;
        d.bus.io_sel = 1'b0;
        // Two-clock state from a phase divider
        d.ph = ~q.ph; // [RULE_22]
        if (q.ph) begin
            d.cnt = q.cnt + 5'h01;
        end
        case (q.step)
            tcpu_pkg::ST_FETCH: begin
                if (!q.ph) begin
                    // Same read path for code and data
                    d.bus.addr = q.pc; // [RULE_05]
                    d.bus.rd = 1'b1;
                    d.memory_address_latch = q.pc; // [RULE_04]
                end else begin
                    d.ir = mem_rdata;
                    d.pc = q.pc + 12'h001; // [RULE_04] [RULE_23]
                    d.step = tcpu_pkg::ST_DECODE;
                end
            end
            tcpu_pkg::ST_DECODE: begin
                if (q.ph) begin
                    d.ea = ea_form;
                    d.total = total_calc;
                    if (opc == `TCPU_OP_IO) begin
                        d.step = tcpu_pkg::ST_IO;
                    end else if (opc == `TCPU_OP_OPR) begin
                        d.step = tcpu_pkg::ST_EXEC;
                    end else if (q.ir[`TCPU_IND_BIT]) begin
                        d.step = tcpu_pkg::ST_PTR; // [RULE_11]
                    end else begin
                        d.step = after_ea;
                    end
                end
            end
            tcpu_pkg::ST_PTR: begin
                if (!q.ph) begin
                    d.bus.addr = q.ea;
                    d.bus.rd = 1'b1;
                end else if (is_auto) begin
                    d.mb = mem_rdata + 12'h001; // [RULE_12] [RULE_23]
                    d.step = tcpu_pkg::ST_AUTOWB;
                end else begin
                    d.ea = mem_rdata; // [RULE_11]
                    d.step = after_ea;
                end
            end
            tcpu_pkg::ST_AUTOWB: begin
                if (!q.ph) begin
                    // Incremented pointer is restored before use
                    d.bus.addr = q.ea;
                    d.bus.wdata = q.mb;
                    d.bus.wr = 1'b1; // [RULE_12]
                end else begin
                    d.ea = q.mb; // [RULE_12]
                    d.step = after_ea;
                end
            end
            tcpu_pkg::ST_OPRD: begin
                if (!q.ph) begin
                    d.bus.addr = q.ea;
                    d.bus.rd = 1'b1;
                end else begin
                    d.mb = mem_rdata;
                    d.step = tcpu_pkg::ST_EXEC;
                end
            end
            tcpu_pkg::ST_EXEC: begin
                if (q.ph) begin
                    d.step = tcpu_pkg::ST_PAD;
                    case (opc)
                        `TCPU_OP_AND,
                        `TCPU_OP_ADD: begin
                            // Memory word is left untouched
                            d.ac = alu_ac; // [RULE_13] [RULE_14]
                            d.lnk = alu_lnk; // [RULE_01]
                        end
                        `TCPU_OP_ISZ: begin
                            d.mb = q.mb + 12'h001; // [RULE_15] [RULE_23]
                            d.step = tcpu_pkg::ST_WB;
                        end
                        `TCPU_OP_DCA: begin
                            d.mb = q.ac; // [RULE_16]
                            d.step = tcpu_pkg::ST_WB;
                        end
                        `TCPU_OP_CALL: begin
                            d.mb = q.pc; // [RULE_17]
                            d.step = tcpu_pkg::ST_WB;
                        end
                        `TCPU_OP_BR: d.pc = q.ea; // [RULE_18]
                        default: begin
                            d.ac = alu_ac; // [RULE_20] [RULE_02]
                            d.lnk = alu_lnk;
                            d.mq = alu_mq;
                            if (alu_skip) begin
                                d.pc = q.pc + 12'h001; // [RULE_23]
                            end
                        end
                    endcase
                end
            end
            tcpu_pkg::ST_WB: begin
                if (!q.ph) begin
                    d.bus.addr = q.ea;
                    d.bus.wdata = q.mb;
                    d.bus.wr = 1'b1;
                end else begin
                    d.step = tcpu_pkg::ST_PAD;
                    case (opc)
                        `TCPU_OP_DCA: d.ac = '0; // [RULE_16]
                        `TCPU_OP_CALL: d.pc = q.ea + 12'h001; // [RULE_17] [RULE_23]
                        default: begin
                            if (q.mb == '0) begin
                                d.pc = q.pc + 12'h001; // [RULE_15]
                            end
                        end
                    endcase
                end
            end
            tcpu_pkg::ST_IO: begin
                if (!q.ph) begin
                    // Instruction goes out as device address
                    d.bus.addr = q.ir;
                    d.bus.wdata = q.ac;
                    d.bus.io_sel = 1'b1; // [RULE_19]
                end else begin
                    d.step = tcpu_pkg::ST_PAD;
                    if (io_rsp.jump) begin
                        // Vector wins over load and skip
                        d.pc = io_rsp.data; // [RULE_21]
                    end else begin
                        if (io_rsp.ac_load) begin
                            d.ac = io_rsp.data; // [RULE_19]
                        end
                        if (io_rsp.skip) begin
                            d.pc = q.pc + 12'h001;
                        end
                    end
                end
            end
            tcpu_pkg::ST_PAD: begin
                // Hold until the state count is used up
                if (q.ph && (q.cnt + 5'h01 >= q.total)) begin
                    d.cnt = 5'h00; // [RULE_22]
                    d.step = tcpu_pkg::ST_FETCH;
                end
            end
            default: begin
                d.step = tcpu_pkg::ST_FETCH;
                d.cnt = 5'h00;
            end
        endcase
    end

    // ==========
    // State register; reset clears all
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========
    // Outputs straight from the state register
    assign bus = q.bus;
    assign working_register = q.ac;
    assign link = q.lnk;
    assign multiply_quotient_register = q.mq;
    assign instruction_pointer = q.pc;
    assign held_instruction = q.ir;
    assign step = q.step;
endmodule : tcpu_core

// ---- tcpu_regs.svh ----
// Constants of the twelve-bit processor core: fields, opcodes, state counts
//
// Overview of operation
// RULE_01: One-bit link extends working register, carry complements
// RULE_02: Multiply-quotient register ORs into or swaps working
// RULE_03: Twelve-bit ALU: add, AND, OR, rotate, increment, tests
// RULE_04: Fetch copies pointer to address latch, then increments
// RULE_05: Instruction and data words are treated alike
// RULE_06: 4096 words in 32 pages of 128
// RULE_07: Top five address bits page, low seven offset
// RULE_08: Current page comes from the fetch address
// RULE_09: Top three bits opcode, low nine operand field
// RULE_10: Page bit clear means page zero, else current
// RULE_11: Indirect bit reads pointer as effective address
// RULE_12: Pointers 0010-0017 octal pre-increment and write back
// RULE_13: Opcode 0 ANDs operand; 10, 15, 16 states
// RULE_14: Opcode 1 adds operand; carry complements the link
// RULE_15: Opcode 2 increments operand, skips on zero
// RULE_16: Opcode 3 stores working register then clears it
// RULE_17: Opcode 4 stores pointer, jumps to address plus one
// RULE_18: Opcode 5 loads effective address into pointer
// RULE_19: Opcode 6 runs peripheral transfer, 17 states
// RULE_20: Opcode 7 operate microinstructions, 10 or 15 states
// RULE_21: Peripheral may supply a branch target during transfer
// RULE_22: Each state lasts two input clock periods
// RULE_23: All increments wrap modulo 4096
`ifndef TCPU_REGS_SVH
`define TCPU_REGS_SVH

// ==========
// Word and field layout
`define TCPU_W 12
`define TCPU_OPC_HI 11
`define TCPU_OPC_LO 9
`define TCPU_IND_BIT 8
`define TCPU_CUR_BIT 7
`define TCPU_PAGE_HI 11
`define TCPU_PAGE_LO 7
`define TCPU_OFS_HI 6
`define TCPU_AUTO_TAG 9'h001

// ==========
// Opcodes
`define TCPU_OP_AND 3'h0
`define TCPU_OP_ADD 3'h1
`define TCPU_OP_ISZ 3'h2
`define TCPU_OP_DCA 3'h3
`define TCPU_OP_CALL 3'h4
`define TCPU_OP_BR 3'h5
`define TCPU_OP_IO 3'h6
`define TCPU_OP_OPR 3'h7

// ==========
// Per-instruction state counts
`define TCPU_ST_SHORT 5'h0a
`define TCPU_ST_LONG 5'h0b
`define TCPU_ST_ISZ 5'h10
`define TCPU_ST_IO 5'h11
`define TCPU_ST_OPR_ROT 5'h0f
`define TCPU_ST_IND 5'h05
`define TCPU_ST_AUTO 5'h01

`endif

// ---- tcpu_pkg.sv ----
// Types shared by the twelve-bit processor core, its checks, memory model and bench
`include "tcpu_regs.svh"
package tcpu_pkg;
    typedef enum logic [3:0] {
        ST_FETCH,
        ST_DECODE,
        ST_PTR,
        ST_AUTOWB,
        ST_OPRD,
        ST_EXEC,
        ST_WB,
        ST_IO,
        ST_PAD
    } tcpu_step_t;

    // Multiplexed bus toward memory and peripherals
    typedef struct packed {
        logic [`TCPU_W-1:0] addr;
        logic [`TCPU_W-1:0] wdata;
        logic rd;
        logic wr;
        logic io_sel;
    } tcpu_bus_t;

    // Peripheral answer to a transfer
    typedef struct packed {
        logic [`TCPU_W-1:0] data;
        logic ac_load;
        logic skip;
        logic jump;
    } tcpu_io_rsp_t;

    // Whole state of the core
    typedef struct packed {
        logic [`TCPU_W-1:0] ac;
        logic lnk;
        logic [`TCPU_W-1:0] mq;
        logic [`TCPU_W-1:0] pc;
        logic [`TCPU_W-1:0] memory_address_latch;
        logic [`TCPU_W-1:0] ir;
        logic [`TCPU_W-1:0] ea;
        logic [`TCPU_W-1:0] mb;
        tcpu_step_t step;
        logic ph;
        logic [4:0] cnt;
        logic [4:0] total;
        tcpu_bus_t bus;
    } tcpu_state_t;
endpackage : tcpu_pkg

// ---- tcpu_alu.sv ----
// Twelve-bit ALU: AND, add and the three operate groups
`timescale 1ns/1ns
`include "tcpu_regs.svh"
module tcpu_alu #(
    parameter int W = `TCPU_W
) (
    input wire logic [2:0] opc,
    input wire logic [W-1:0] ir,
    input wire logic [W-1:0] ac,
    input wire logic lnk,
    input wire logic [W-1:0] mq,
    input wire logic [W-1:0] opnd,
    output logic [W-1:0] ac_o,
    output logic lnk_o,
    output logic [W-1:0] mq_o,
    output logic skip_o
);
    // ==========
    // Elaboration check
    if (W != 12) begin : g_chk
        $error("tcpu_alu serves twelve-bit words only");
    end

    logic [W:0] lw;
    logic [W-1:0] t;
    logic cond;

    // ==========
    // Datapath in microinstruction sequence order
    always_comb begin
        lw = {lnk, ac};
        t = ac;
        cond = 1'b0;
        mq_o = mq;
        skip_o = 1'b0;
        case (opc)
            `TCPU_OP_AND: lw = {lnk, ac & opnd}; // [RULE_13] [RULE_03]
            `TCPU_OP_ADD: begin
                lw = {1'b0, ac} + {1'b0, opnd};
                lw[W] = lw[W] ^ lnk; // Carry complements link [RULE_14] [RULE_01]
            end
            `TCPU_OP_OPR: begin
                if (!ir[8]) begin
                    // Group 1: clear, complement, increment, rotate
                    if (ir[7]) lw[W-1:0] = '0;
                    if (ir[6]) lw[W] = 1'b0;
                    if (ir[5]) lw[W-1:0] = ~lw[W-1:0];
                    if (ir[4]) lw[W] = ~lw[W]; // [RULE_01]
                    if (ir[0]) begin
                        lw[W-1:0] = lw[W-1:0] + 12'h001; // [RULE_23]
                        if (lw[W-1:0] == '0) lw[W] = ~lw[W];
                    end
                    case (ir[3:1])
                        3'h1: lw = {lw[W], lw[5:0], lw[11:6]};
                        3'h2: lw = {lw[W-1:0], lw[W]};
                        3'h3: lw = {lw[W-2:0], lw[W:W-1]};
                        3'h4: lw = {lw[0], lw[W:1]};
                        3'h5: lw = {lw[1:0], lw[W:2]};
                        default: lw = lw;
                    endcase // [RULE_03]
                end else if (!ir[0]) begin
                    // Group 2: skip tests, reverse sense by bit 3
                    cond = (ir[6] & ac[W-1]) | (ir[5] & (ac == '0)) | (ir[4] & lnk);
                    skip_o = ir[3] ? ~cond : cond; // [RULE_03]
                    if (ir[7]) lw[W-1:0] = '0;
                end else begin
                    // Group 3: OR and exchange with quotient register
                    t = ir[7] ? '0 : ac;
                    mq_o = ir[4] ? t : mq;
                    lw[W-1:0] = (ir[4] ? '0 : t) | (ir[6] ? mq : '0); // [RULE_02]
                end
            end
            default: lw = {lnk, ac};
        endcase
        ac_o = lw[W-1:0];
        lnk_o = lw[W];
    end
endmodule : tcpu_alu

// ---- tcpu_core_assertions.sv ----
// Concurrent checks on the ports of the twelve-bit processor core
`timescale 1ns/1ns
module tcpu_core_assertions #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] mem_rdata,
    input wire tcpu_pkg::tcpu_io_rsp_t io_rsp,
    input wire tcpu_pkg::tcpu_bus_t bus,
    input wire logic [W-1:0] working_register,
    input wire logic link,
    input wire logic [W-1:0] multiply_quotient_register,
    input wire logic [W-1:0] instruction_pointer,
    input wire logic [W-1:0] held_instruction,
    input wire tcpu_pkg::tcpu_step_t step
);
    // ==========
    // Helper terms
    logic fetch_rd;
    logic [W-1:0] next_ip;
    logic [W-1:0] fetch_ip;
    logic [W-1:0] dir_ea;
    logic [W-1:0] ptr_inc_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Pointer is one past the fetch; step back for the page
    assign fetch_rd = bus.rd && step == tcpu_pkg::ST_FETCH;
    assign next_ip = bus.addr + 1'b1;
    assign fetch_ip = instruction_pointer - 1'b1;
    assign dir_ea = {held_instruction[7] ? fetch_ip[W-1:7] : 5'h00, held_instruction[6:0]};
    // Pointer word plus one, kept from the pointer read
    always_ff @(posedge clk) begin
        if (bus.rd && step == tcpu_pkg::ST_PTR) begin
            ptr_inc_q <= mem_rdata + 1'b1;
        end
    end
    // ==========
    // Properties
    property p_fetch_addr;
        fetch_rd |-> bus.addr == instruction_pointer;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address is not the pointer");
    property p_fetch_inc;
        fetch_rd |=> instruction_pointer == $past(next_ip) && held_instruction == $past(mem_rdata);
    endproperty
    a_fetch_inc: assert property (p_fetch_inc) else $error("pointer not advanced by fetch");
    property p_strobe_gap;
        (bus.rd || bus.wr || bus.io_sel) |=> !(bus.rd || bus.wr || bus.io_sel);
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("two strobes in one state");
    property p_direct_ea;
        (bus.rd && step == tcpu_pkg::ST_OPRD && !held_instruction[8] && held_instruction[11:9] < 3'h3)
            |-> bus.addr == dir_ea;
    endproperty
    a_direct_ea: assert property (p_direct_ea) else $error("direct operand address wrong");
    property p_ptr_addr;
        (bus.rd && step == tcpu_pkg::ST_PTR) |-> bus.addr == dir_ea && held_instruction[8];
    endproperty
    a_ptr_addr: assert property (p_ptr_addr) else $error("pointer address wrong");
    property p_auto_wb;
        (bus.wr && step == tcpu_pkg::ST_AUTOWB) |-> bus.addr[W-1:3] == 9'h001 && bus.wdata == ptr_inc_q;
    endproperty
    a_auto_wb: assert property (p_auto_wb) else $error("autoindex write wrong");
    property p_auto_taken;
        (bus.rd && step == tcpu_pkg::ST_PTR && held_instruction[7:3] == 5'h01)
            |-> ##[1:3] (bus.wr && step == tcpu_pkg::ST_AUTOWB);
    endproperty
    a_auto_taken: assert property (p_auto_taken) else $error("autoindex pointer not written");
    property p_io_out;
        bus.io_sel |-> bus.addr == held_instruction && bus.wdata == working_register && held_instruction[11:9] == 3'h6;
    endproperty
    a_io_out: assert property (p_io_out) else $error("transfer outputs wrong");
    property p_io_jump;
        (bus.io_sel && io_rsp.jump) |=> instruction_pointer == $past(io_rsp.data);
    endproperty
    a_io_jump: assert property (p_io_jump) else $error("peripheral branch not taken");
    // ==========
    // Coverage of the main paths
    c_autoindex: cover property (bus.wr && step == tcpu_pkg::ST_AUTOWB);
    c_io_jump: cover property (bus.io_sel && io_rsp.jump);
    c_writeback: cover property (bus.wr && step == tcpu_pkg::ST_WB);
endmodule : tcpu_core_assertions

// ---- tcpu_mem_model.sv ----
// Word memory and peripheral stand-in on the far side of the core bus
`timescale 1ns/1ns
module tcpu_mem_model (
    input wire logic clk,
    input wire tcpu_pkg::tcpu_bus_t bus,
    input wire tcpu_pkg::tcpu_io_rsp_t io_ret,
    output logic [11:0] mem_rdata,
    output tcpu_pkg::tcpu_io_rsp_t io_rsp
);
    // One array for code and data
    logic [11:0] mem [4096];
    // Write lands at the edge that ends the strobe
    always @(posedge clk) begin
        if (bus.wr) begin
            mem[bus.addr] <= bus.wdata;
        end
    end
    // Inverse outside a strobe, so stale data never passes
    assign mem_rdata = bus.rd ? mem[bus.addr] : ~mem[bus.addr];
    assign io_rsp = bus.io_sel ? io_ret : ~io_ret;
endmodule : tcpu_mem_model

// ---- test_twelve_bit_cpu_memref_core.sv ----
// Self-checking bench for the twelve-bit processor core
`timescale 1ns/1ns
module test_twelve_bit_cpu_memref_core;
    logic clk, rst_n, link;
    logic [11:0] mem_rdata, working_register, multiply_quotient_register, instruction_pointer, held_instruction;
    tcpu_pkg::tcpu_io_rsp_t io_rsp, io_ret;
    tcpu_pkg::tcpu_bus_t bus;
    tcpu_pkg::tcpu_step_t step;
    int errors = 0, n_compared = 0, cyc = 0, tn = 0;
    int ft[$];
    logic [11:0] fa[$];
    logic [31:0] rs;
    logic [11:0] ops[10] = '{12'he21, 12'he04, 12'he02, 12'he50, 12'hf11, 12'hf20, 12'hf40, 12'hc05, 12'hc06, 12'hc07};
    int base[6] = '{10, 10, 16, 11, 11, 10};

    tcpu_core DUT (.clk(clk), .rst_n(rst_n), .mem_rdata(mem_rdata), .io_rsp(io_rsp), .bus(bus),
        .working_register(working_register), .link(link), .multiply_quotient_register(multiply_quotient_register),
        .instruction_pointer(instruction_pointer), .held_instruction(held_instruction), .step(step));
    tcpu_mem_model mm (.clk(clk), .bus(bus), .io_ret(io_ret), .mem_rdata(mem_rdata), .io_rsp(io_rsp));

    always #2 clk = ~clk;
    // Fetch log: address and cycle
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rst_n && bus.rd && step == tcpu_pkg::ST_FETCH) begin
            fa.push_back(bus.addr);
            ft.push_back(cyc);
        end
    end
    // ==========
    // Bench functions and tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Branch-to-self word on the current page
    function automatic logic [11:0] lw(input logic [11:0] x);
        return {3'h5, 2'b01, x[6:0]};
    endfunction : lw
    function automatic int mri_states(input int op, input int m);
        return base[op] + (m == 2 ? 5 : (m == 3 ? 6 : 0));
    endfunction : mri_states
    task automatic nxt;
        repeat (32) rs = lfsr(rs);
    endtask : nxt
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // Harness: load a, jump indirect to b
    task automatic setup(input logic [11:0] a, input logic [11:0] b);
        for (int i = 0; i < 4096; i++) mm.mem[i] = 12'h000;
        mm.mem[0] = 12'hec0;
        mm.mem[1] = 12'h220;
        mm.mem[2] = 12'hb21;
        mm.mem[12'h020] = a;
        mm.mem[12'h021] = b;
        mm.mem[b + 12'h1] = lw(b + 12'h1);
        mm.mem[b + 12'h2] = lw(b + 12'h2);
    endtask : setup
    // Reset, run past b, check flow, timing, registers
    task automatic go(input logic [11:0] b, n, ac_e, mq_e, input logic l_e, input int st);
        int k;
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        fa.delete();
        ft.delete();
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        k = 0;
        while (fa.size() < 5 && k < 300) begin
            @(posedge clk);
            k++;
        end
        #1;
        chk(fa[3], b);
        chk(fa[4], n);
        chk(ft[4] - ft[3], 2 * st);
        chk(working_register, ac_e);
        chk(link, l_e);
        chk(multiply_quotient_register, mq_e);
        tn++;
        $display("test %0d done", tn);
    endtask : go
    // ==========
    // Main sequence
    initial begin
        logic [11:0] a, d, b, ea, e, n, ac, mq, w, iw;
        logic l;
        logic [4:0] p;
        logic [2:0] r;
        int st;
        clk = 1'b0;
        rst_n = 1'b0;
        io_ret = '0;
        rs = 32'h00015611;
        // Memory opcodes in all four modes
        for (int op = 0; op < 6; op++) begin
            for (int m = 0; m < 4; m++) begin
                nxt;
                a = rs[11:0];
                d = rs[23:12];
                r = rs[26:24];
                p = {1'b0, rs[29:27], 1'b1};
                b = {p, 7'h40};
                e = {p + 5'h10, 4'h7, r};
                if (op == 2 && m == 1) d = 12'hfff;
                setup(a, b);
                case (m)
                    0: ea = {5'h00, 4'h2, r};
                    1: ea = {p, 4'h1, r};
                    default: ea = e;
                endcase
                iw = {op[2:0], m > 1, m == 1, m == 2 ? {4'h5, r} : (m == 3 ? {4'h1, r} : ea[6:0])};
                mm.mem[{5'h00, 4'h5, r}] = e;
                mm.mem[{9'h001, r}] = e - 12'h1;
                mm.mem[ea] = d;
                mm.mem[b] = iw;
                n = b + 12'h1;
                ac = a;
                l = 1'b0;
                w = d;
                case (op)
                    0: ac = a & d;
                    1: {l, ac} = a + d;
                    2: begin
                        w = d + 12'h1;
                        if (w == 12'h000) n = b + 12'h2;
                    end
                    3: begin
                        w = a;
                        ac = 12'h000;
                    end
                    4: begin
                        w = b + 12'h1;
                        n = ea + 12'h1;
                    end
                    default: n = ea;
                endcase
                if (op >= 4) mm.mem[n] = lw(n);
                if (op == 5) w = lw(n);
                go(b, n, ac, 12'h000, l, mri_states(op, m));
                chk(mm.mem[ea], w);
                if (m == 3) chk(mm.mem[{9'h001, r}], e);
            end
        end
        // Operate and transfer words; pass 1 with zero working value
        for (int pass = 0; pass < 2; pass++) begin
            for (int k = 0; k < 10; k++) begin
                nxt;
                a = pass ? 12'h000 : rs[11:0];
                d = rs[23:12];
                p = {1'b0, rs[29:27], 1'b1};
                b = {p, 7'h40};
                iw = ops[k];
                setup(a, b);
                mm.mem[b] = iw;
                n = b + 12'h1;
                ac = a;
                l = 1'b0;
                mq = 12'h000;
                st = 10;
                case (iw)
                    12'he21: {l, ac} = {1'b0, ~a} + 13'h0001;
                    12'he04: begin
                        {l, ac} = {a, 1'b0};
                        st = 15;
                    end
                    12'he02: begin
                        ac = {a[5:0], a[11:6]};
                        st = 15;
                    end
                    12'he50: l = 1'b1;
                    12'hf11: begin
                        mq = a;
                        ac = 12'h000;
                    end
                    12'hf20: if (a == 12'h000) n = b + 12'h2;
                    12'hf40: if (a[11]) n = b + 12'h2;
                    12'hc05: begin
                        d = {p + 5'h10, 7'h40};
                        n = d;
                        mm.mem[d] = lw(d);
                        st = 17;
                    end
                    12'hc06: begin
                        ac = d;
                        st = 17;
                    end
                    default: begin
                        n = b + 12'h2;
                        st = 17;
                    end
                endcase
                io_ret = {d, iw == 12'hc06, iw == 12'hc07, iw == 12'hc05};
                go(b, n, ac, mq, l, st);
            end
        end
        stop_test;
    end
    // Watchdog at over five times the expected run
    initial begin
        #100000;
        errors++;
        stop_test;
    end
endmodule : test_twelve_bit_cpu_memref_core

bind tcpu_core tcpu_core_assertions #(.W(W)) u_chk (.clk(clk), .rst_n(rst_n), .mem_rdata(mem_rdata),
    .io_rsp(io_rsp), .bus(bus), .working_register(working_register), .link(link),
    .multiply_quotient_register(multiply_quotient_register), .instruction_pointer(instruction_pointer),
    .held_instruction(held_instruction), .step(step));
